/* File: design/awd_map.vh */
// Register offsets, reset values and field positions of the window detector
`ifndef AWD_MAP_VH
`define AWD_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define AWD_UPPER_LO_ADDR 8'hc4
`define AWD_UPPER_HI_ADDR 8'hc5
`define AWD_LOWER_LO_ADDR 8'hc6
`define AWD_LOWER_HI_ADDR 8'hc7
`define AWD_CTRL_ADDR 8'hc8
`define AWD_STATUS_ADDR 8'hc9
`define AWD_MASK_ADDR 8'hca
`define AWD_RESULT_LO_ADDR 8'hcb
`define AWD_RESULT_HI_ADDR 8'hcc

// ****************************************
// Reset values
// ****************************************
`define AWD_UPPER_LO_RST 8'h00
`define AWD_UPPER_HI_RST 8'hff
`define AWD_LOWER_LO_RST 8'h00
`define AWD_LOWER_HI_RST 8'h00
`define AWD_CTRL_RST 8'h00
`define AWD_MASK_RST 8'h00

// ****************************************
// Field positions
// ****************************************
`define AWD_CTRL_LJUST_BIT 0
`define AWD_CTRL_DIFF_BIT 1
`define AWD_STAT_MATCH_BIT 0
`define AWD_STAT_EOC_BIT 1
`define AWD_STAT_OVR_BIT 2

`endif

/* File: design/awd_compare.v */
// Signed or unsigned window comparison of one result word against two limits
`timescale 1ns/10ps
`default_nettype none

module awd_compare (
  input wire [15:0] result_i,
  input wire [15:0] upper_i,
  input wire [15:0] lower_i,
  input wire signed_i,
  output wire match_o
);

  wire [16:0] res_x;
  wire [16:0] up_x;
  wire [16:0] lo_x;
  wire above_upper;
  wire below_lower;
  wire lower_gt_upper;

  // Extending by one bit lets a single signed compare serve both number forms
  assign res_x = {signed_i & result_i[15], result_i};
  assign up_x = {signed_i & upper_i[15], upper_i};
  assign lo_x = {signed_i & lower_i[15], lower_i};

  assign above_upper = $signed(res_x) > $signed(up_x);
  assign below_lower = $signed(res_x) < $signed(lo_x);
  assign lower_gt_upper = $signed(lo_x) > $signed(up_x);

  assign match_o = lower_gt_upper ? (above_upper & below_lower) : (above_upper | below_lower);

endmodule

`default_nettype wire

/* File: design/awd_window_detector.v */
// Converter window detector: limit registers, compare on end of conversion, flag and interrupt
//
// Summary of operation
// - Every new result is compared with both limits; match sets flag, else flag holds
// - Comparison happens on the end-of-conversion event only
// - Match flag can raise an interrupt and is readable for polling
// - Upper limit word is high byte over low byte
// - Lower limit word is high byte over low byte
// - Lower above upper: match when result strictly inside both limits
// - Lower not above upper: match when result below lower or above upper
// - Differential results and limits compare as signed 16-bit values
// - Left-justified results compare as presented, ten bits high, zeros below
// - Upper high byte resets to ones, lower low byte to zeros; all bits read/write
// - Right-justified: ten bits low, sign extension or zeros above
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "awd_map.vh"

module awd_window_detector (
  input wire clk_i,
  input wire reset_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire eoc_i,
  input wire [9:0] sample_i,
  output wire left_justify_select_o,
  output wire differential_o,
  output wire [15:0] result_word_o,
  output wire window_match_flag_o,
  output wire irq_o
);

  // ****************************************
  // Register state
  // ****************************************
  reg [7:0] upper_lo_q;
  reg [7:0] upper_hi_q;
  reg [7:0] lower_lo_q;
  reg [7:0] lower_hi_q;
  reg [7:0] ctrl_q;
  reg [2:0] status_q;
  reg [2:0] status_d;
  reg [2:0] mask_q;
  reg [15:0] result_q;
  reg [7:0] rdata_d;
  wire [15:0] upper_word;
  wire [15:0] lower_word;
  wire [15:0] new_word;
  wire ljust;
  wire diff;
  wire match;
  wire status_rd;
  reg [7:0] upper_lo_d;
  reg [7:0] upper_hi_d;
  reg [7:0] lower_lo_d;
  reg [7:0] lower_hi_d;
  reg [7:0] ctrl_d;
  reg [2:0] mask_d;
  reg [15:0] result_d;
  reg [7:0] rdata_next;
  wire wr_upper_lo;
  wire wr_upper_hi;
  wire wr_lower_lo;
  wire wr_lower_hi;
  wire wr_ctrl;
  wire wr_mask;
  wire [15:0] left_word;
  wire [15:0] right_word;
  wire [5:0] sign_ext;
  wire match_evt;
  wire eoc_evt;
  wire overrun_evt;
  wire [7:0] status_byte;
  wire [7:0] mask_byte;
  wire [7:0] result_lo_byte;
  wire [7:0] result_hi_byte;

  // ****************************************
  // Control fields
  // ****************************************
  assign ljust = ctrl_q[`AWD_CTRL_LJUST_BIT];
  assign diff = ctrl_q[`AWD_CTRL_DIFF_BIT];

  // ****************************************
  // Limit words
  // ****************************************
  // Limits are read straight from the byte registers, so any write counts at once
  assign upper_word = {upper_hi_q, upper_lo_q};
  assign lower_word = {lower_hi_q, lower_lo_q};

  // ****************************************
  // Result word formatting
  // ****************************************
  // Single-ended extension is zeros; differential copies the sample sign
  assign sign_ext = {6{diff & sample_i[9]}};
  assign left_word = {sample_i, 6'h00};
  assign right_word = {sign_ext, sample_i};
  assign new_word = ljust ? left_word : right_word;

  // ****************************************
  // Window comparison
  // ****************************************
  // Compare the fresh word, not the stored one, so the flag lands with the result
  awd_compare u_compare (
    .result_i(new_word),
    .upper_i(upper_word),
    .lower_i(lower_word),
    .signed_i(diff),
    .match_o(match)
  );

  // ****************************************
  // Write decode
  // ****************************************
  // One enable per writable register; an unmapped address matches none of them
  assign wr_upper_lo = wr_i && (addr_i == `AWD_UPPER_LO_ADDR);
  assign wr_upper_hi = wr_i && (addr_i == `AWD_UPPER_HI_ADDR);
  assign wr_lower_lo = wr_i && (addr_i == `AWD_LOWER_LO_ADDR);
  assign wr_lower_hi = wr_i && (addr_i == `AWD_LOWER_HI_ADDR);
  assign wr_ctrl = wr_i && (addr_i == `AWD_CTRL_ADDR);
  assign wr_mask = wr_i && (addr_i == `AWD_MASK_ADDR);

  // ****************************************
  // Upper limit, low byte
  // ****************************************
  always @* begin
    upper_lo_d = upper_lo_q;
    if (wr_upper_lo) begin
      upper_lo_d = wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      upper_lo_q <= `AWD_UPPER_LO_RST;
    end else begin
      upper_lo_q <= upper_lo_d;
    end
  end

  // ****************************************
  // Upper limit, high byte
  // ****************************************
  always @* begin
    upper_hi_d = upper_hi_q;
    if (wr_upper_hi) begin
      upper_hi_d = wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      upper_hi_q <= `AWD_UPPER_HI_RST;
    end else begin
      upper_hi_q <= upper_hi_d;
    end
  end

  // ****************************************
  // Lower limit, low byte
  // ****************************************
  always @* begin
    lower_lo_d = lower_lo_q;
    if (wr_lower_lo) begin
      lower_lo_d = wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      lower_lo_q <= `AWD_LOWER_LO_RST;
    end else begin
      lower_lo_q <= lower_lo_d;
    end
  end

  // ****************************************
  // Lower limit, high byte
  // ****************************************
  always @* begin
    lower_hi_d = lower_hi_q;
    if (wr_lower_hi) begin
      lower_hi_d = wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      lower_hi_q <= `AWD_LOWER_HI_RST;
    end else begin
      lower_hi_q <= lower_hi_d;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = {6'h00, wdata_i[1:0]};
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `AWD_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ****************************************
  // Interrupt mask
  // ****************************************
  always @* begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = wdata_i[2:0];
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      mask_q <= 3'h0;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ****************************************
  // Last result
  // ****************************************
  always @* begin
    result_d = result_q;
    if (eoc_i) begin
      result_d = new_word;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      result_q <= 16'h0000;
    end else begin
      result_q <= result_d;
    end
  end

  // ****************************************
  // Sticky status, cleared by reading it
  // ****************************************
  // Bit 2 flags a conversion that arrived while an earlier one was unread
  assign match_evt = eoc_i & match;
  assign eoc_evt = eoc_i;
  assign overrun_evt = eoc_i & status_q[`AWD_STAT_EOC_BIT];
  assign status_rd = rd_i && (addr_i == `AWD_STATUS_ADDR);

  always @* begin
    status_d = status_q;
    if (status_rd) begin
      status_d = 3'h0;
    end
    // A set in the same cycle as the clearing read wins
    if (match_evt) begin
      status_d[`AWD_STAT_MATCH_BIT] = 1'b1;
    end
    if (eoc_evt) begin
      status_d[`AWD_STAT_EOC_BIT] = 1'b1;
    end
    if (overrun_evt) begin
      status_d[`AWD_STAT_OVR_BIT] = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      status_q <= 3'h0;
    end else begin
      status_q <= status_d;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  assign irq_o = |(status_q & mask_q);

  // ****************************************
  // Read data selection
  // ****************************************
  assign status_byte = {5'h00, status_q};
  assign mask_byte = {5'h00, mask_q};
  assign result_lo_byte = result_q[7:0];
  assign result_hi_byte = result_q[15:8];

  always @* begin
    case (addr_i)
      `AWD_UPPER_LO_ADDR: rdata_d = upper_lo_q;
      `AWD_UPPER_HI_ADDR: rdata_d = upper_hi_q;
      `AWD_LOWER_LO_ADDR: rdata_d = lower_lo_q;
      `AWD_LOWER_HI_ADDR: rdata_d = lower_hi_q;
      `AWD_CTRL_ADDR: rdata_d = ctrl_q;
      `AWD_STATUS_ADDR: rdata_d = status_byte;
      `AWD_MASK_ADDR: rdata_d = mask_byte;
      `AWD_RESULT_LO_ADDR: rdata_d = result_lo_byte;
      `AWD_RESULT_HI_ADDR: rdata_d = result_hi_byte;
      default: rdata_d = 8'h00;
    endcase
  end

  // ****************************************
  // Read port, data one cycle after the strobe
  // ****************************************
  // Idle cycles return zero so a stale byte is never taken for an answer
  always @* begin
    rdata_next = 8'h00;
    if (rd_i) begin
      rdata_next = rdata_d;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign left_justify_select_o = ljust;
  assign differential_o = diff;
  assign result_word_o = result_q;
  assign window_match_flag_o = status_q[`AWD_STAT_MATCH_BIT];

endmodule

`default_nettype wire

/* File: testbench/awd_chk_assertions.sv */
// Port-level checker of the window detector
`timescale 1ns/10ps
`default_nettype none
module awd_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic eoc_i,
  input wire logic [9:0] sample_i,
  input wire logic left_justify_select_o,
  input wire logic differential_o,
  input wire logic [15:0] result_word_o,
  input wire logic window_match_flag_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // A status read at the same edge as an event keeps the event, so it is left out
  sequence s_clr; rd_i && addr_i == 8'hc9 && !eoc_i; endsequence
  property p_rise; $rose(window_match_flag_o) |-> $past(eoc_i); endproperty
  a_rise: assert property (p_rise) else $error("flag rose without conversion");
  property p_hold; window_match_flag_o && !(rd_i && addr_i == 8'hc9) |=> window_match_flag_o; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_rd; rd_i && addr_i == 8'hc9 |=> rdata_o[0] == $past(window_match_flag_o); endproperty
  a_rd: assert property (p_rd) else $error("status read wrong");
  property p_clr; s_clr |=> !window_match_flag_o; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_lj; eoc_i && left_justify_select_o |=> result_word_o == {$past(sample_i), 6'h00}; endproperty
  a_lj: assert property (p_lj) else $error("left word wrong");
  property p_rj; eoc_i && !left_justify_select_o |=> result_word_o[9:0] == $past(sample_i) &&
    result_word_o[15:10] == {6{result_word_o[9] & $past(differential_o)}}; endproperty
  a_rj: assert property (p_rj) else $error("right word wrong");
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_irq; $rose(irq_o) |-> $past(eoc_i) || $past(wr_i); endproperty
  a_irq: assert property (p_irq) else $error("irq rose without cause");
endmodule
bind awd_window_detector awd_chk u_chk (.*);
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the window detector
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic wr_i = 0;
  logic rd_i = 0;
  logic eoc_i = 0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [9:0] sample_i = 10'h000;
  logic [7:0] rdata_o, d;
  logic [15:0] result_word_o;
  logic [15:0] w;
  logic left_justify_select_o, differential_o, window_match_flag_o, irq_o;
  int n_errors = 0;
  int tests_run = 0;
  // Sets of control, upper word, lower word; four samples each straddle both limits
  logic [33:0] cfg [5] = '{{2'h0, 16'h0100, 16'h0200}, {2'h0, 16'h0200, 16'h0100}, {2'h2, 16'hffff, 16'h0100},
    {2'h1, 16'h4000, 16'h8000}, {2'h2, 16'h0100, 16'hffff}};
  logic [9:0] smp [20] = '{10'h100, 10'h101, 10'h1ff, 10'h200, 10'h0ff, 10'h100, 10'h200, 10'h201, 10'h3ff,
    10'h000, 10'h0ff, 10'h100, 10'h200, 10'h1ff, 10'h101, 10'h100, 10'h3fe, 10'h3ff, 10'h100, 10'h101};
  logic [19:0] hit = 20'b01101001011001101001;
  logic [7:0] rsv [4] = '{8'h00, 8'hff, 8'h00, 8'h00};
  awd_window_detector dut_u (.*);
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (e !== g) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic cnv(input logic [9:0] s);
    @(posedge clk_i);
    sample_i <= s;
    eoc_i <= 1'b1;
    @(posedge clk_i);
    eoc_i <= 1'b0;
    #1;
  endtask
  task automatic t_regs;
    for (logic [7:0] a = 8'hc4; a < 8'hc8; a++) begin
      rd(a);
      chk("limit reset", rsv[a[1:0]], d);
      wr(a, 8'h5a ^ a);
      rd(a);
      chk("limit readback", 8'h5a ^ a, d);
    end
    rd(8'hf0);
    chk("unmapped", 8'h00, d);
  endtask
  task automatic t_window;
    for (int c = 0; c < 5; c++) begin
      wr(8'hc8, {6'h3f, cfg[c][33:32]});
      rd(8'hc8);
      chk("control readback", {6'h00, cfg[c][33:32]}, d);
      chk("mode outputs", {6'h00, cfg[c][33:32]}, {6'h00, differential_o, left_justify_select_o});
      wr(8'hc5, cfg[c][31:24]);
      wr(8'hc4, cfg[c][23:16]);
      wr(8'hc7, cfg[c][15:8]);
      wr(8'hc6, cfg[c][7:0]);
      for (int k = 0; k < 4; k++) begin
        rd(8'hc9);
        cnv(smp[c * 4 + k]);
        w = cfg[c][32] ? {smp[c * 4 + k], 6'h00} : {{6{cfg[c][33] & smp[c * 4 + k][9]}}, smp[c * 4 + k]};
        chk("result word low", w[7:0], result_word_o[7:0]);
        chk("result word high", w[15:8], result_word_o[15:8]);
        rd(8'hc9);
        chk("window match", {7'h00, hit[19 - c * 4 - k]}, d & 8'h01);
        chk("conversion done", 8'h02, d & 8'h02);
        rd(8'hcb);
        chk("result low byte", w[7:0], d);
        rd(8'hcc);
        chk("result high byte", w[15:8], d);
      end
    end
  endtask
  task automatic t_irq;
    wr(8'hca, 8'hf9);
    rd(8'hca);
    chk("mask readback", 8'h01, d);
    rd(8'hc9);
    chk("irq idle", 8'h00, {7'h00, irq_o});
    cnv(10'h3fe);
    chk("irq raised", 8'h01, {7'h00, irq_o});
    wr(8'hca, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq_o});
    chk("flag held", 8'h01, {7'h00, window_match_flag_o});
    rd(8'hc9);
    chk("flag cleared", 8'h00, {7'h00, window_match_flag_o});
  endtask
  task automatic t_overrun;
    cnv(10'h100);
    cnv(10'h100);
    rd(8'hc9);
    chk("overrun status", 8'h06, d);
    rd(8'hc9);
    chk("status cleared", 8'h00, d);
  endtask
  task automatic t_race;
    @(posedge clk_i);
    addr_i <= 8'hc9;
    rd_i <= 1'b1;
    sample_i <= 10'h3fe;
    eoc_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    eoc_i <= 1'b0;
    #1 d = rdata_o;
    chk("race read", 8'h00, d);
    chk("set wins", 8'h01, {7'h00, window_match_flag_o});
    rd(8'hc9);
    chk("race status", 8'h03, d);
  endtask
  task automatic t_reset;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(8'hc5);
    chk("upper high after reset", 8'hff, d);
    rd(8'hcc);
    chk("result after reset", 8'h00, d);
    chk("flag after reset", 8'h00, {7'h00, window_match_flag_o});
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_window();
    t_irq();
    t_overrun();
    t_race();
    t_reset();
    close_out();
  end
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
